// File: include/sbw_pkg.sv
// shared constants, types and helpers for the burst memory write/output control
package sbw_pkg;
  localparam int unsigned LANE_W      = 9;             // one data byte plus its parity bit
  localparam int unsigned LANES       = 2;             // low lane and high lane
  localparam int unsigned DATA_W      = LANE_W * LANES;
  localparam int unsigned LOW_LSB     = 0;             // low byte and parity sit in bits 8..0
  localparam int unsigned HIGH_LSB    = 9;             // high byte and parity sit in bits 17..9
  localparam int unsigned WAKE_CYCLES = 2;             // wake-up time after sleep, in cycles
  localparam logic [1:0]  WAKE_LAST   = 2'h1;          // wake count loaded on leaving sleep
  localparam logic [1:0]  LANES_NONE  = 2'h0;
  localparam logic [1:0]  LANES_ALL   = 2'h3;
  localparam logic [17:0] DATA_RST    = 18'h0_0000;

  // operating modes, one-hot
  typedef enum logic [3:0] {
    SBW_STANDBY = 4'h1,                                // clocked standby, pins off
    SBW_ACTIVE  = 4'h2,                                // selected, reading or writing
    SBW_SLEEP   = 4'h4,                                // power-down, contents kept
    SBW_WAKE    = 4'h8                                 // wake-up wait after sleep
  } sbw_mode_t;

  // host strobes sampled on the rising edge
  typedef struct packed {
    logic primary_chip_select_n;
    logic global_write_all_n;
    logic byte_write_qualifier_n;
    logic lane_low_write_n;
    logic lane_high_write_n;
    logic output_enable_n;
  } sbw_ctl_t;

  // write lane decode: bit 0 is the low lane, bit 1 the high lane
  function automatic logic [1:0] write_lanes(input sbw_ctl_t c);
    logic [1:0] l;
    l = LANES_NONE;
    if (!c.global_write_all_n) begin
      l = LANES_ALL;
    end else if (!c.byte_write_qualifier_n) begin
      l = {~c.lane_high_write_n, ~c.lane_low_write_n};
    end
    return l;
  endfunction

  // lanes written last cycle come from the write register, the rest from the array
  function automatic logic [17:0] merge(input logic [1:0] l, input logic [17:0] w,
                                        input logic [17:0] a);
    logic [17:0] m;
    m = a;
    if (l[0]) begin
      m[LOW_LSB +: LANE_W] = w[LOW_LSB +: LANE_W];
    end
    if (l[1]) begin
      m[HIGH_LSB +: LANE_W] = w[HIGH_LSB +: LANE_W];
    end
    return m;
  endfunction
endpackage

// File: src/sbw_ctl.sv
// byte-write decode, output drive and write-to-read pass-through of a burst memory
//
// Contract
// - read after full write shows written word
// - read after one-lane write shows that lane
// - no new cycle: no carryover, drive if enabled
// - undriven sleep pin reads as inactive
// - sleep forces pins off, keeps contents
// - deselected: pins off, clocked standby
// - global write all lanes, else qualified lanes
// - write sampled turns drivers off, latches data
// - two wake cycles after sleep, no accesses
`timescale 1ns/1ps
`default_nettype none
module sbw_ctl (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // host strobes and selects
  input  wire sbw_pkg::sbw_ctl_t host_ctl,
  input  wire logic              chip_select_aux,
  input  wire logic              sleep_request,
  input  wire logic              sleep_driven,
  // host data pins
  input  wire logic [17:0]       dq_in,
  output logic      [17:0]       dq_out,
  output logic                   dq_oe_n,
  // storage array
  input  wire logic [17:0]       array_rd_data,
  output logic      [1:0]        array_we,
  output logic      [17:0]       array_wr_data,
  // status
  output logic                   awake
);

  // whole module state in one record
  typedef struct packed {
    sbw_pkg::sbw_mode_t mode;       // operating mode
    logic [1:0]         wake_cnt;   // wake cycles still to wait
    logic [1:0]         prev_lanes; // lanes written in the last cycle
    logic [17:0]        prev_wdata; // word written in the last cycle
    logic [17:0]        dq;         // output data register
    logic               oe_n;       // output driver enable, low drives
    logic [1:0]         we;         // array lane write strobes
    logic [17:0]        wdata;      // array write data
    logic               awake;      // accesses are accepted
  } sbw_state_t;

  sbw_state_t s;                    // current state
  sbw_state_t next_s;               // next state
  logic       sleep_eff;            // sleep with the internal pull-down applied
  logic       sel;                  // device selected this edge
  logic [1:0] lanes;                // decoded write lanes

  // a floating pin is pulled low, so only a driven high means sleep
  assign sleep_eff = sleep_driven & sleep_request;
  assign sel       = ~host_ctl.primary_chip_select_n & chip_select_aux;
  assign lanes     = sbw_pkg::write_lanes(host_ctl);

  // next-state logic
  always_comb begin
    next_s       = s;
    next_s.we    = sbw_pkg::LANES_NONE;
    next_s.awake = 1'b0;
    if (sleep_eff) begin
      // power-down: pins off whatever the output enable says, array untouched
      next_s.mode       = sbw_pkg::SBW_SLEEP;
      next_s.oe_n       = 1'b1;
      next_s.prev_lanes = sbw_pkg::LANES_NONE;
    end else begin
      case (s.mode)
        sbw_pkg::SBW_SLEEP: begin
          // leaving sleep: hold off accesses for the wake time
          next_s.mode     = sbw_pkg::SBW_WAKE;
          next_s.wake_cnt = sbw_pkg::WAKE_LAST;
        end
        sbw_pkg::SBW_WAKE: begin
          // the last wait edge hands over to standby, so the edge after it is served;
          // waiting one edge longer would stretch the wake time past two cycles
          next_s.wake_cnt = s.wake_cnt - 2'h1;
          if (s.wake_cnt <= sbw_pkg::WAKE_LAST) begin
            next_s.mode     = sbw_pkg::SBW_STANDBY;
            next_s.wake_cnt = 2'h0;
            next_s.awake    = 1'b1;
          end
        end
        sbw_pkg::SBW_STANDBY, sbw_pkg::SBW_ACTIVE: begin
          next_s.awake = 1'b1;
          if (sel && lanes != sbw_pkg::LANES_NONE) begin
            // write: drivers off regardless of output enable, data latched
            next_s.mode       = sbw_pkg::SBW_ACTIVE;
            next_s.oe_n       = 1'b1;
            next_s.we         = lanes;
            next_s.wdata      = dq_in;
            next_s.prev_lanes = lanes;
            next_s.prev_wdata = dq_in;
          end else if (sel) begin
            // read: written lanes pass through, others from the array
            next_s.mode       = sbw_pkg::SBW_ACTIVE;
            next_s.dq         = sbw_pkg::merge(s.prev_lanes, s.prev_wdata,
                                               array_rd_data);
            next_s.oe_n       = host_ctl.output_enable_n;
            next_s.prev_lanes = sbw_pkg::LANES_NONE;
          end else begin
            // no new cycle: one look at the last write, then nothing carried
            next_s.mode       = sbw_pkg::SBW_STANDBY;
            next_s.prev_lanes = sbw_pkg::LANES_NONE;
            if (s.prev_lanes != sbw_pkg::LANES_NONE) begin
              next_s.dq   = sbw_pkg::merge(s.prev_lanes, s.prev_wdata, array_rd_data);
              next_s.oe_n = host_ctl.output_enable_n;
            end else begin
              next_s.oe_n = 1'b1;
            end
          end
        end
        default: begin
          // illegal code: recover to standby with pins off
          next_s.mode = sbw_pkg::SBW_STANDBY;
          next_s.oe_n = 1'b1;
        end
      endcase
    end
  end

  // state register; the chip keeps no reset pin, this one is for the system
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s.mode       <= sbw_pkg::SBW_STANDBY;
      s.wake_cnt   <= 2'h0;
      s.prev_lanes <= sbw_pkg::LANES_NONE;
      s.prev_wdata <= sbw_pkg::DATA_RST;
      s.dq         <= sbw_pkg::DATA_RST;
      s.oe_n       <= 1'b1;
      s.we         <= sbw_pkg::LANES_NONE;
      s.wdata      <= sbw_pkg::DATA_RST;
      s.awake      <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs are state fields, so each is a flip-flop
  assign dq_out        = s.dq;
  assign dq_oe_n       = s.oe_n;
  assign array_we      = s.we;
  assign array_wr_data = s.wdata;
  assign awake         = s.awake;

  // bus contention is left to the host dropping output enable before writes

  // assertions sit beside the logic they guard; all are off while reset is held
  logic normal; // state accepts accesses
  assign normal = (s.mode == sbw_pkg::SBW_STANDBY) || (s.mode == sbw_pkg::SBW_ACTIVE);

  property p_sleep_off;
    @(posedge ref_clk) disable iff (rst) sleep_eff |=> dq_oe_n && array_we == 2'h0;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep left pins driven");

  property p_pull_down;
    @(posedge ref_clk) disable iff (rst) !sleep_driven |=> s.mode != sbw_pkg::SBW_SLEEP;
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("floating sleep slept");

  property p_write_off;
    @(posedge ref_clk) disable iff (rst)
      normal && !sleep_eff && sel && lanes != 2'h0 |=> dq_oe_n && array_we == $past(lanes)
        && array_wr_data == $past(dq_in);
  endproperty
  a_write_off: assert property (p_write_off) else $error("write did not latch");

  property p_global_all;
    @(posedge ref_clk) disable iff (rst)
      normal && !sleep_eff && sel && !host_ctl.global_write_all_n |=> array_we == 2'h3;
  endproperty
  a_global_all: assert property (p_global_all) else $error("global write missed a lane");

  property p_pass_all;
    @(posedge ref_clk) disable iff (rst)
      normal && !sleep_eff && sel && lanes == 2'h3 ##1 (sel && lanes == 2'h0 && !sleep_eff)
        |=> dq_out == $past(dq_in, 2);
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("full write not passed through");

  property p_pass_low;
    @(posedge ref_clk) disable iff (rst)
      s.prev_lanes == 2'h1 && normal && !sleep_eff && sel && lanes == 2'h0
        |=> dq_out[8:0] == $past(s.prev_wdata[8:0])
          && dq_out[17:9] == $past(array_rd_data[17:9]);
  endproperty
  a_pass_low: assert property (p_pass_low) else $error("lane pass-through wrong");

  property p_pass_high;
    @(posedge ref_clk) disable iff (rst)
      s.prev_lanes == 2'h2 && normal && !sleep_eff && sel && lanes == 2'h0
        |=> dq_out[17:9] == $past(s.prev_wdata[17:9])
          && dq_out[8:0] == $past(array_rd_data[8:0]);
  endproperty
  a_pass_high: assert property (p_pass_high) else $error("high lane pass-through wrong");

  property p_no_carry;
    @(posedge ref_clk) disable iff (rst)
      s.prev_lanes != 2'h0 && normal && !sleep_eff && !sel
        |=> dq_oe_n == $past(host_ctl.output_enable_n) ##1 ($past(sel) || dq_oe_n);
  endproperty
  a_no_carry: assert property (p_no_carry) else $error("write carried over");

  property p_desel;
    @(posedge ref_clk) disable iff (rst)
      s.prev_lanes == 2'h0 && normal && !sleep_eff && !sel |=> dq_oe_n && array_we == 2'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("deselected device drove pins");

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
      s.mode == sbw_pkg::SBW_SLEEP && !sleep_eff |=> (array_we == 2'h0 && !awake)
        ##1 (array_we == 2'h0 && awake == !$past(sleep_eff));
  endproperty
  a_wake: assert property (p_wake) else $error("access during wake-up");

endmodule
`default_nettype wire

// File: bench/sbw_array_model.sv
// storage array stand-in: read word changes every cycle, lane writes fold in
`timescale 1ns/1ps
`default_nettype none
module sbw_array_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // array side of the block
  input  wire logic [1:0]  array_we,
  input  wire logic [17:0] array_wr_data,
  output logic      [17:0] array_rd_data
);
  // a fresh word each cycle stands for a new read address, so a stale lane shows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      array_rd_data <= 18'h0_5a5a;
    end else begin
      // each lane strobe folds in its own byte and parity only
      array_rd_data <= (array_rd_data + 18'h0_9d35) ^
                       ({{9{array_we[1]}}, {9{array_we[0]}}} & array_wr_data);
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the burst memory write and output control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [5:0] RD   = 6'h1e;  // selected read, output enabled
  localparam logic [5:0] DES  = 6'h3f;  // deselected, output disabled
  localparam logic [5:0] DOE  = 6'h3e;  // deselected, output enabled
  localparam logic [5:0] WALL = 6'h0f;  // all-lane write, output disabled
  localparam logic [2:0] N    = 3'h6;   // pin driven, aux selected, awake
  logic              ref_clk;           // 10 MHz clock
  logic              rst;               // synchronous reset
  sbw_pkg::sbw_ctl_t host_ctl;          // host strobes
  logic              aux;               // other chip selects
  logic              sleep_request;     // sleep pin level
  logic              sleep_driven;      // low floats the sleep pin
  logic [17:0]       dq_in, dq_out, array_rd_data, array_wr_data, d, a;
  logic              dq_oe_n, awake;    // drive enable and status
  logic [1:0]        array_we;          // lane write pulses
  logic [5:0]        c;                 // strobe word of this pass
  logic [2:0]        k, r;              // mode and random strobes
  int                err_count, num_checks;

  sbw_ctl sbw_ctl_i (.ref_clk(ref_clk), .rst(rst), .host_ctl(host_ctl),
    .chip_select_aux(aux), .sleep_request(sleep_request), .sleep_driven(sleep_driven),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .array_rd_data(array_rd_data),
    .array_we(array_we), .array_wr_data(array_wr_data), .awake(awake));
  sbw_array_model sbw_array_model_i (.ref_clk(ref_clk), .rst(rst), .array_we(array_we),
    .array_wr_data(array_wr_data), .array_rd_data(array_rd_data));

  // expected lanes: all-lane strobe wins, else qualified lane strobes
  function automatic logic [1:0] exp_lanes(input logic [5:0] s);
    if (!s[4]) return 2'h3;
    if (!s[3]) return {~s[1], ~s[2]};
    return 2'h0;
  endfunction

  // expected pass-through word: written lanes from w, the rest from the array
  function automatic logic [17:0] exp_merge(input logic [1:0] l, input logic [17:0] w,
                                            input logic [17:0] x);
    logic [17:0] m;
    m = x;
    if (l[0]) m[8:0] = w[8:0];
    if (l[1]) m[17:9] = w[17:9];
    return m;
  endfunction

  // one cycle: new inputs on the edge, then let that edge's outputs settle
  task automatic step(input logic [5:0] s, input logic [17:0] v, input logic [2:0] p);
    @(posedge ref_clk);
    host_ctl      <= sbw_pkg::sbw_ctl_t'(s);
    dq_in         <= v;
    {sleep_driven, aux, sleep_request} <= p;
    #1;
  endtask

  task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // watchdog, far beyond the hundred or so cycles the sequence needs
  initial begin
    repeat (1000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    host_ctl = sbw_pkg::sbw_ctl_t'(DES);
    {sleep_driven, aux, sleep_request} = N;
    dq_in = 18'h0_0000;
    err_count = 0;
    num_checks = 0;
    void'($urandom(32'h7f727014));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("oe after reset", dq_oe_n, 1'b1);
    chk("awake after reset", awake, 1'b0);
    // random write then back-to-back reads, every lane decode in turn
    for (int i = 0; i < 20; i++) begin
      k = 3'(i % 5);
      r = 3'($urandom);
      c = (k == 3'h0) ? {2'b00, r, 1'b0} : (k == 3'h4) ? {3'b011, r[1:0], 1'b1} :
          {3'b010, ~k[0], ~k[1], 1'b1};
      d = 18'($urandom);
      step(c, d, N);                                      // oe high unless all-lane write
      step(RD, 18'h0_0000, N);
      chk("lane strobes", array_we, exp_lanes(c));
      if (exp_lanes(c) != 2'h0) begin
        chk("write data", array_wr_data, d);
        chk("write drive off", dq_oe_n, 1'b1);
      end
      a = array_rd_data;
      step(RD, 18'h0_0000, N);
      chk("pass data", dq_out, exp_merge(exp_lanes(c), d, a));
      chk("pass drive", dq_oe_n, 1'b0);
      a = array_rd_data;
      step(DES, 18'h0_0000, N);
      chk("next read", dq_out, a);
    end
    // no new cycle after a write: one cycle of data only if enabled
    d = 18'($urandom);
    step(WALL, d, N);
    step(DOE, 18'h0_0000, N);
    step(DES, 18'h0_0000, N);
    chk("idle data", dq_out, d);
    chk("idle drive", dq_oe_n, 1'b0);
    step(DES, 18'h0_0000, N);
    chk("no carryover", dq_oe_n, 1'b1);
    step(WALL, d, N);
    step(DES, 18'h0_0000, N);
    step(DES, 18'h0_0000, N);
    chk("idle off", dq_oe_n, 1'b1);
    // aux select off: nothing written, pins off despite oe low
    step(6'h0e, d, 3'h4);
    step(RD, 18'h0_0000, 3'h4);
    chk("deselect write", array_we, 2'h0);
    step(RD, 18'h0_0000, 3'h4);
    chk("deselect drive", dq_oe_n, 1'b1);
    // floating sleep pin reads as inactive
    step(WALL, d, 3'h3);
    step(RD, 18'h0_0000, 3'h3);
    chk("floating sleep", array_we, 2'h3);
    chk("floating awake", awake, 1'b1);
    // sleep, write refused, then two wake edges ignore accesses
    step(DES, 18'h0_0000, 3'h7);
    step(WALL, d, 3'h7);
    chk("sleep drive", dq_oe_n, 1'b1);
    chk("sleep awake", awake, 1'b0);
    step(RD, 18'h0_0000, 3'h7);
    chk("sleep write", array_we, 2'h0);
    step(WALL, d, N);
    for (int j = 0; j < 2; j++) begin
      step(WALL, d, N);
      chk("wake ignore", array_we, 2'h0);
    end
    step(RD, 18'h0_0000, N);
    chk("wake accept", array_we, 2'h3);
    stop_test();
  end
endmodule
`default_nettype wire
